// ==== rtl/acb_params.svh ====
// Purpose: constants of the converter control block
// Assumes: included by bare name from the package and the bench
// Notes: offsets are AHB byte addresses, one word per register
`ifndef ACB_PARAMS_SVH
`define ACB_PARAMS_SVH

`define ACB_NPINS 16
`define ACB_BUF_DEPTH 16
`define ACB_HALF_DEPTH 8

`define ACB_OFS_CTRL1 8'h00
`define ACB_OFS_CTRL2 8'h04
`define ACB_OFS_PCFG 8'h08
`define ACB_OFS_PORT 8'h0c
`define ACB_OFS_CLKCFG 8'h10
`define ACB_OFS_SCAN 8'h14
`define ACB_OFS_DMACFG 8'h18
`define ACB_OFS_BUF_PAGE 2'h1

`define ACB_RST_CTRL1 16'h0000
`define ACB_RST_CTRL2 16'h0000
`define ACB_RST_PCFG 16'h0000
`define ACB_RST_CLKCFG 16'h0000
`define ACB_RST_SCAN 16'h0000
`define ACB_RST_DMACFG 2'h0

`define ACB_BIT_ON 15
`define ACB_BIT_SIMULTANEOUS_SAMPLE_SEL 3
`define ACB_BIT_AUTO_SAMPLE_ENABLE 2
`define ACB_BIT_DONE 0
`define ACB_LSB_SSRC 5
`define ACB_LSB_CHPS 8
`define ACB_BIT_ACTIVE_HALF_STATUS 7
`define ACB_LSB_SMPI 2
`define ACB_BIT_SPLIT_BUFFER_MODE 1
`define ACB_BIT_ALTERNATE_INPUT_ENABLE 0
`define ACB_BIT_DMA_EN 0
`define ACB_BIT_CONV_ORDER 1

`endif

// ==== rtl/acb_pkg.sv ====
// Purpose: types of the converter control block
// Assumes: acb_params.svh holds all numeric constants
// Notes: none
package acb_pkg;
`include "acb_params.svh"

   typedef struct packed {
      logic [1:0] channel_count_sel;
      logic [3:0] per_interrupt_count;
      logic split_buffer_mode;
      logic alternate_input_enable;
   } acb_ctrl2_t;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
   } acb_ahb_req_t;

   typedef enum logic [1:0] {
      ACB_BUS_IDLE = 2'b01,
      ACB_BUS_RDWAIT = 2'b10
   } acb_bus_state_t;

endpackage : acb_pkg

// ==== rtl/acb_ctrl.sv ====
// Purpose: pin setup, enable, interrupt counting and result buffering of a SAR converter
// Assumes: converter core and sequencer on clk_i; pads and power control asynchronous
// Notes: AHB-Lite slave, writes zero wait, reads one wait state
//
// What this block does
// R1: digital-select bit zero makes pin analog
// R2: reset clears the pin configuration register
// R3: analog pins disable their digital input buffer
// R4: digital pins ground their multiplexer input
// R5: port reads return zero on analog pins
// R6: converter-on bit powers module fully
// R7: clearing converter-on halts all sequencing
// R8: abort conversion, never store partial result
// R9: software leaves settings alone while on
// R10: power-disable stops clock, toggle restores defaults
// R11: power-disable forces pins digital, ignores selects
// R12: with DMA count sets address increment rate
// R13: conversion-order DMA ignores the count field
// R14: software zeroes count under plain DMA
// R15: DMA variant interrupts and completes every conversion
// R16: fill 16-word buffer, interrupt at count
// R17: conversions equal count plus one, times channels when sampling is simultaneous
// R18: software limits count in simultaneous modes
// R19: completion bit set with interrupt, cleared next
// R20: split mode alternates 8-word halves per interrupt
// R21: unsplit mode uses whole 16-word buffer
// R22: active-half bit shows half being filled
// R23: interrupt restarts the sequencing from beginning
// R24: power-disable ignores writes, holds defaults
`timescale 1ns/1ps
`default_nettype none
module acb_ctrl
   import acb_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic module_power_disable_i,
   input wire logic [`ACB_NPINS-1:0] port_pin_i,
   output logic [`ACB_NPINS-1:0] digital_in_buf_en_o,
   output logic [`ACB_NPINS-1:0] mux_to_ground_o,
   input wire logic seq_start_i,
   input wire logic conv_done_i,
   input wire logic [15:0] conv_result_i,
   output logic conv_enable_o,
   output logic conv_clk_en_o,
   output logic conv_abort_o,
   output logic seq_restart_o,
   output logic irq_o,
   output logic dma_req_o,
   output logic dma_addr_inc_o,
   output logic [15:0] dma_data_o
);

   logic pd_s1_q, pd_q;
   logic [`ACB_NPINS-1:0] pin_s1_q, pin_q;
   logic [15:0] ctrl1_q, pcfg_q, clkcfg_q, scan_q;
   acb_ctrl2_t ctrl2_q;
   logic [1:0] dmacfg_q;
   logic done_q, half_q;
   logic [4:0] cnt_q;
   logic [6:0] dma_cnt_q;
   logic [15:0] buf_q [`ACB_BUF_DEPTH];
   acb_bus_state_t bus_q;
   acb_ahb_req_t req_q;
   logic wr_pend_q;

   // pads and power control come from other domains
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pd_s1_q <= 1'b0;
         pd_q <= 1'b0;
         pin_s1_q <= '0;
         pin_q <= '0;
      end else begin
         pd_s1_q <= module_power_disable_i;
         pd_q <= pd_s1_q;
         pin_s1_q <= port_pin_i;
         pin_q <= pin_s1_q;
      end
   end

   logic on_eff;
   logic [`ACB_NPINS-1:0] eff_dig;
   logic dma_en, conv_order;
   assign on_eff = ctrl1_q[`ACB_BIT_ON] & ~pd_q; // R6 R7
   assign eff_dig = pcfg_q | {`ACB_NPINS{pd_q}}; // R1 R11
   assign dma_en = dmacfg_q[`ACB_BIT_DMA_EN];
   assign conv_order = dmacfg_q[`ACB_BIT_CONV_ORDER];

   // ---------------- conversion counting ----------------
   logic [2:0] mult, nch;
   logic [6:0] target, eff_target, limit, dma_target;
   logic accept, irq_now, wr_en;
   logic [3:0] wr_idx;

   always_comb begin
      nch = 3'd1;
      if (ctrl2_q.channel_count_sel == 2'b01) begin
         nch = 3'd2;
      end else if (ctrl2_q.channel_count_sel[1]) begin
         nch = 3'd4;
      end
      // sequential sampling converts one channel per sample
      mult = ctrl1_q[`ACB_BIT_SIMULTANEOUS_SAMPLE_SEL] ? nch : 3'd1; // R17
      target = 7'({3'b000, ctrl2_q.per_interrupt_count} + 7'd1) * 7'(mult); // R17
      limit = ctrl2_q.split_buffer_mode ? 7'(`ACB_HALF_DEPTH) : 7'(`ACB_BUF_DEPTH); // R20 R21
      // clamp keeps a bad count from overrunning the buffer
      eff_target = (target > limit) ? limit : target; // R16
      dma_target = conv_order ? 7'd1 : 7'(({3'b000, ctrl2_q.per_interrupt_count} + 7'd1) * 7'(nch)); // R12 R13
   end

   assign accept = conv_done_i & on_eff; // R8
   assign irq_now = accept & (dma_en | (7'({2'b00, cnt_q} + 7'd1) == eff_target)); // R15 R16
   assign wr_en = accept & ~dma_en; // R8 R16
   assign wr_idx = ctrl2_q.split_buffer_mode ? {half_q, cnt_q[2:0]} : cnt_q[3:0]; // R20 R21

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         half_q <= 1'b0;
      end else if (!on_eff) begin
         cnt_q <= '0; // R7
         half_q <= 1'b0;
      end else if (irq_now) begin
         cnt_q <= '0; // R23
         if (ctrl2_q.split_buffer_mode) begin
            half_q <= ~half_q; // R20 R22
         end
      end else if (accept) begin
         cnt_q <= cnt_q + 5'd1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_q <= 1'b0;
      end else if (pd_q) begin
         done_q <= 1'b0;
      end else if (irq_now) begin
         done_q <= 1'b1; // R19
      end else if (seq_start_i) begin
         done_q <= 1'b0; // R19
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dma_cnt_q <= '0;
         dma_addr_inc_o <= 1'b0;
      end else begin
         dma_addr_inc_o <= 1'b0;
         if (!on_eff || !dma_en) begin
            dma_cnt_q <= '0;
         end else if (accept) begin
            if (dma_cnt_q + 7'd1 >= dma_target) begin
               dma_cnt_q <= '0;
               dma_addr_inc_o <= 1'b1; // R12 R13
            end else begin
               dma_cnt_q <= dma_cnt_q + 7'd1;
            end
         end
      end
   end

   // result storage, no reset needed on data but kept defined
   genvar gi;
   generate
      for (gi = 0; gi < `ACB_BUF_DEPTH; gi++) begin : g_buf
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               buf_q[gi] <= '0;
            end else if (pd_q) begin
               buf_q[gi] <= '0;
            end else if (wr_en && wr_idx == 4'(gi)) begin
               buf_q[gi] <= conv_result_i; // R16
            end
         end
      end
   endgenerate

   // ---------------- converter side outputs ----------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conv_enable_o <= 1'b0;
         conv_clk_en_o <= 1'b1;
         conv_abort_o <= 1'b0;
         seq_restart_o <= 1'b0;
         irq_o <= 1'b0;
         dma_req_o <= 1'b0;
         dma_data_o <= '0;
         digital_in_buf_en_o <= '0;
         mux_to_ground_o <= '0;
      end else begin
         conv_enable_o <= on_eff; // R6
         conv_clk_en_o <= ~pd_q; // R10
         conv_abort_o <= conv_enable_o & ~on_eff; // R7 R8
         seq_restart_o <= irq_now; // R23
         irq_o <= irq_now; // R15 R16
         dma_req_o <= accept & dma_en; // R15
         if (accept && dma_en) begin
            dma_data_o <= conv_result_i;
         end
         digital_in_buf_en_o <= eff_dig; // R3
         mux_to_ground_o <= eff_dig; // R4
      end
   end

   // ---------------- AHB-Lite slave ----------------
   logic addr_ok, do_write;
   logic [15:0] wdata;
   assign addr_ok = hsel_i & hready_i & htrans_i[1];
   assign do_write = wr_pend_q & ~pd_q; // R24
   assign wdata = hwdata_i[15:0];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_q <= ACB_BUS_IDLE;
         req_q <= '0;
         wr_pend_q <= 1'b0;
         hreadyout_o <= 1'b1;
      end else begin
         case (bus_q)
            ACB_BUS_IDLE: begin
               wr_pend_q <= addr_ok & hwrite_i;
               req_q <= addr_ok ? {haddr_i[7:0], hwrite_i} : req_q;
               if (addr_ok && !hwrite_i) begin
                  bus_q <= ACB_BUS_RDWAIT;
                  hreadyout_o <= 1'b0;
               end
            end
            ACB_BUS_RDWAIT: begin
               bus_q <= ACB_BUS_IDLE;
               hreadyout_o <= 1'b1;
            end
            default: begin
               bus_q <= ACB_BUS_IDLE;
               hreadyout_o <= 1'b1;
            end
         endcase
      end
   end

   // registers; power-disable holds them at default so its release restores them
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl1_q <= `ACB_RST_CTRL1;
         ctrl2_q <= acb_ctrl2_t'(`ACB_RST_CTRL2);
         pcfg_q <= `ACB_RST_PCFG; // R2
         clkcfg_q <= `ACB_RST_CLKCFG;
         scan_q <= `ACB_RST_SCAN;
         dmacfg_q <= `ACB_RST_DMACFG;
      end else if (pd_q) begin
         ctrl1_q <= `ACB_RST_CTRL1; // R10 R24
         ctrl2_q <= acb_ctrl2_t'(`ACB_RST_CTRL2);
         pcfg_q <= `ACB_RST_PCFG;
         clkcfg_q <= `ACB_RST_CLKCFG;
         scan_q <= `ACB_RST_SCAN;
         dmacfg_q <= `ACB_RST_DMACFG;
      end else if (do_write) begin
         if (req_q.addr == `ACB_OFS_CTRL1) begin
            ctrl1_q <= {wdata[15:1], 1'b0}; // completion bit is hardware owned
         end else if (req_q.addr == `ACB_OFS_CTRL2) begin
            ctrl2_q <= {wdata[`ACB_LSB_CHPS +: 2], wdata[`ACB_LSB_SMPI +: 4],
                        wdata[`ACB_BIT_SPLIT_BUFFER_MODE], wdata[`ACB_BIT_ALTERNATE_INPUT_ENABLE]};
         end else if (req_q.addr == `ACB_OFS_PCFG) begin
            pcfg_q <= wdata; // R1
         end else if (req_q.addr == `ACB_OFS_CLKCFG) begin
            clkcfg_q <= wdata;
         end else if (req_q.addr == `ACB_OFS_SCAN) begin
            scan_q <= wdata;
         end else if (req_q.addr == `ACB_OFS_DMACFG) begin
            dmacfg_q <= wdata[1:0];
         end
      end
   end

   logic [15:0] rd_val;
   logic [15:0] port_val;
   assign port_val = pin_q & eff_dig; // R5

   always_comb begin
      rd_val = 16'h0000;
      if (req_q.addr == `ACB_OFS_CTRL1) begin
         rd_val = {ctrl1_q[15:1], done_q}; // R19
      end else if (req_q.addr == `ACB_OFS_CTRL2) begin
         rd_val = 16'h0000;
         rd_val[`ACB_LSB_CHPS +: 2] = ctrl2_q.channel_count_sel;
         rd_val[`ACB_BIT_ACTIVE_HALF_STATUS] = half_q & ctrl2_q.split_buffer_mode; // R22
         rd_val[`ACB_LSB_SMPI +: 4] = ctrl2_q.per_interrupt_count;
         rd_val[`ACB_BIT_SPLIT_BUFFER_MODE] = ctrl2_q.split_buffer_mode;
         rd_val[`ACB_BIT_ALTERNATE_INPUT_ENABLE] = ctrl2_q.alternate_input_enable;
      end else if (req_q.addr == `ACB_OFS_PCFG) begin
         rd_val = pcfg_q;
      end else if (req_q.addr == `ACB_OFS_PORT) begin
         rd_val = port_val; // R5
      end else if (req_q.addr == `ACB_OFS_CLKCFG) begin
         rd_val = clkcfg_q;
      end else if (req_q.addr == `ACB_OFS_SCAN) begin
         rd_val = scan_q;
      end else if (req_q.addr == `ACB_OFS_DMACFG) begin
         rd_val = {14'h0000, dmacfg_q};
      end else if (req_q.addr[7:6] == `ACB_OFS_BUF_PAGE) begin
         rd_val = buf_q[req_q.addr[5:2]];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hrdata_o <= '0;
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
         if (bus_q == ACB_BUS_RDWAIT) begin
            hrdata_o <= {16'h0000, rd_val};
         end
      end
   end

   // ---------------- checks ----------------
   property p_pd_defaults;
      @(posedge clk_i) disable iff (!arst_n_i)
      pd_q |=> (pcfg_q == 16'h0000 && ctrl1_q == 16'h0000 && !done_q);
   endproperty
   a_pd_defaults: assert property (p_pd_defaults) else $error("registers not at default under power-disable"); // R24

   property p_analog_buf;
      @(posedge clk_i) disable iff (!arst_n_i)
      (!pcfg_q[0] && !pd_q) ##1 1'b1 |-> !digital_in_buf_en_o[0];
   endproperty
   a_analog_buf: assert property (p_analog_buf) else $error("analog pin kept digital buffer"); // R3

   property p_ground;
      @(posedge clk_i) disable iff (!arst_n_i)
      (pcfg_q[1] || pd_q) |=> mux_to_ground_o[1];
   endproperty
   a_ground: assert property (p_ground) else $error("digital pin not grounded at mux"); // R4

   property p_port_zero;
      @(posedge clk_i) disable iff (!arst_n_i)
      (bus_q == ACB_BUS_RDWAIT && req_q.addr == `ACB_OFS_PORT) |=> ((hrdata_o[15:0] & ~$past(eff_dig)) == 16'h0000);
   endproperty
   a_port_zero: assert property (p_port_zero) else $error("analog pin read as one"); // R5

   property p_abort;
      @(posedge clk_i) disable iff (!arst_n_i)
      (conv_done_i && !on_eff) |-> (!wr_en && !irq_now) ##1 !irq_o;
   endproperty
   a_abort: assert property (p_abort) else $error("result stored while off"); // R8

   property p_irq_done;
      @(posedge clk_i) disable iff (!arst_n_i)
      irq_now |=> (done_q && irq_o && seq_restart_o && cnt_q == 5'd0);
   endproperty
   a_irq_done: assert property (p_irq_done) else $error("completion not set with interrupt"); // R19

   property p_dma_irq;
      @(posedge clk_i) disable iff (!arst_n_i)
      (accept && dma_en) |=> (irq_o && dma_req_o);
   endproperty
   a_dma_irq: assert property (p_dma_irq) else $error("no interrupt after dma conversion"); // R15

   property p_half;
      @(posedge clk_i) disable iff (!arst_n_i)
      (irq_now && ctrl2_q.split_buffer_mode && !pd_q) |=> (half_q != $past(half_q));
   endproperty
   a_half: assert property (p_half) else $error("split half did not switch"); // R20

   property p_clk;
      @(posedge clk_i) disable iff (!arst_n_i)
      pd_q |=> !conv_clk_en_o ##1 !conv_enable_o;
   endproperty
   a_clk: assert property (p_clk) else $error("converter clock runs under power-disable"); // R10

   property p_full;
      @(posedge clk_i) disable iff (!arst_n_i)
      (wr_en && !ctrl2_q.split_buffer_mode) |-> (wr_idx == cnt_q[3:0] && cnt_q < 5'd16);
   endproperty
   a_full: assert property (p_full) else $error("unsplit write index wrong"); // R21

endmodule : acb_ctrl
`default_nettype wire

// ==== tb/acb_conv_model.sv ====
// Purpose: behavioural converter core feeding the control block
// Assumes: bench pulses start_i for one cycle and holds count_i, gap_i, seed_i
// Notes: gap_i must be at least one; idle result bus shows the inverted last word
`timescale 1ns/1ps
`default_nettype none
module acb_conv_model (
   input wire logic clk_i,
   input wire logic conv_enable_i,
   input wire logic start_i,
   input wire logic [4:0] count_i,
   input wire logic [4:0] gap_i,
   input wire logic [15:0] seed_i,
   output logic seq_start_o,
   output logic conv_done_o,
   output logic [15:0] conv_result_o,
   output logic busy_o
);
   initial begin
      seq_start_o = 1'b0;
      conv_done_o = 1'b0;
      conv_result_o = 16'h0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (start_i === 1'b1) begin
            busy_o <= 1'b1;
            seq_start_o <= 1'b1;
            @(posedge clk_i);
            seq_start_o <= 1'b0;
            for (int i = 0; i < int'(count_i); i++) begin
               repeat (gap_i) @(posedge clk_i);
               // a switched-off converter never finishes its word
               if (conv_enable_i !== 1'b1) break;
               conv_done_o <= 1'b1;
               conv_result_o <= seed_i + 16'(i);
               @(posedge clk_i);
               conv_done_o <= 1'b0;
               conv_result_o <= ~(seed_i + 16'(i));
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule : acb_conv_model
`default_nettype wire

// ==== tb/test_acb_ctrl.sv ====
// Purpose: self-checking bench of acb_ctrl
// Assumes: single AHB master; converter core from acb_conv_model
// Notes: pulses counted on the falling edge, clear of launch races
`timescale 1ns/1ps
`default_nettype none
`include "acb_params.svh"
module test_acb_ctrl;
   logic clk_i, arst_n_i, hsel, hwrite, pd, start, hrdy, hresp, cen, cclk, abrt, rstr, irq, dreq, dinc;
   logic sst, cdone, busy;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] pins, seed, din_en, mgnd, cres, ddata;
   logic [4:0] cnt, gap;
   int n_mismatch = 0, samples_checked = 0, n_irq = 0, n_rst = 0, n_abort = 0, n_req = 0, n_inc = 0, cyc = 0;
   localparam logic [31:0] ON = 32'h8000;

   acb_ctrl DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata), .hreadyout_o(hrdy),
      .hresp_o(hresp), .hrdata_o(hrdata), .module_power_disable_i(pd), .port_pin_i(pins),
      .digital_in_buf_en_o(din_en), .mux_to_ground_o(mgnd), .seq_start_i(sst), .conv_done_i(cdone),
      .conv_result_i(cres), .conv_enable_o(cen), .conv_clk_en_o(cclk), .conv_abort_o(abrt),
      .seq_restart_o(rstr), .irq_o(irq), .dma_req_o(dreq), .dma_addr_inc_o(dinc), .dma_data_o(ddata));
   acb_conv_model conv (.clk_i(clk_i), .conv_enable_i(cen), .start_i(start), .count_i(cnt), .gap_i(gap),
      .seed_i(seed), .seq_start_o(sst), .conv_done_o(cdone), .conv_result_o(cres), .busy_o(busy));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      n_irq += int'(irq === 1'b1);
      n_rst += int'(rstr === 1'b1);
      n_abort += int'(abrt === 1'b1);
      n_req += int'(dreq === 1'b1);
      n_inc += int'(dinc === 1'b1);
   end
   // whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("mismatch at %0t: run timed out", $time);
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int k);
      repeat (k) @(posedge clk_i);
   endtask : wt

   // hold each phase until ready is sampled high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge clk_i);
      while (hrdy !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_i);
      while (hrdy !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      rd = hrdata;
      if (n >= 40) begin
         n_mismatch++;
         $display("mismatch at %0t: bus ready timed out", $time);
      end
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   task automatic cfg(input logic [31:0] c1, input logic [31:0] c2);
      bus(1'b1, `ACB_OFS_CTRL1, 32'h0);
      bus(1'b1, `ACB_OFS_CTRL2, c2);
      bus(1'b1, `ACB_OFS_CTRL1, c1);
   endtask : cfg

   task automatic go(input logic [4:0] c, input logic [4:0] g, input logic [15:0] s);
      cnt <= c;
      gap <= g;
      seed <= s;
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      @(posedge clk_i);
   endtask : go

   task automatic fin;
      int n;
      n = 0;
      while (busy === 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      wt(3);
   endtask : fin

   task automatic t_reset;
      rdchk(`ACB_OFS_CTRL1, 32'h0);
      rdchk(`ACB_OFS_CTRL2, 32'h0);
      rdchk(`ACB_OFS_PCFG, 32'h0);
      rdchk(`ACB_OFS_SCAN, 32'h0);
      rdchk(8'h30, 32'h0);
      chk({16'h0, din_en}, 32'h0);
      chk({31'h0, cclk}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_pins;
      bus(1'b1, `ACB_OFS_PCFG, 32'h00f0);
      wt(3);
      chk({16'h0, din_en}, 32'h00f0);
      chk({16'h0, mgnd}, 32'h00f0);
      rdchk(`ACB_OFS_PORT, 32'h0050);
      $display("test pins done");
   endtask : t_pins

   task automatic t_count;
      logic [31:0] c1v [5] = '{ON, ON | 32'h8, ON | 32'h8, ON, ON};
      logic [31:0] c2v [5] = '{32'h0c, 32'h108, 32'h204, 32'h110, 32'h3c};
      int nv [5] = '{4, 6, 8, 5, 16};
      int b, r;
      for (int i = 0; i < 5; i++) begin
         cfg(c1v[i], c2v[i]);
         // enable output trails the register write by a cycle
         wt(2);
         chk({31'h0, cen}, 32'h1);
         b = n_irq;
         r = n_rst;
         go(5'(nv[i]), 5'd1, 16'(i * 4096));
         fin;
         chk(n_irq - b, 1);
         chk(n_rst - r, 1);
         rdchk(8'h40 + 8'(4 * (nv[i] - 1)), {16'h0, 16'(i * 4096 + nv[i] - 1)});
         rdchk(`ACB_OFS_CTRL1, c1v[i] | 32'h1);
      end
      $display("test count done");
   endtask : t_count

   task automatic t_split;
      cfg(ON, 32'h0e);
      rdchk(`ACB_OFS_CTRL2, 32'h0e);
      go(5'd4, 5'd1, 16'h2000);
      fin;
      rdchk(`ACB_OFS_CTRL2, 32'h8e);
      go(5'd4, 5'd20, 16'h3000);
      rdchk(`ACB_OFS_CTRL1, ON);
      fin;
      rdchk(8'h60, 32'h3000);
      rdchk(8'h4c, 32'h2003);
      rdchk(`ACB_OFS_CTRL2, 32'h0e);
      $display("test split done");
   endtask : t_split

   task automatic t_abort;
      int b, a;
      cfg(ON, 32'h0);
      b = n_irq;
      a = n_abort;
      // word finishes one cycle after the enable bit is cleared
      go(5'd1, 5'd3, 16'h4000);
      bus(1'b1, `ACB_OFS_CTRL1, 32'h0);
      wt(2);
      chk({31'h0, cen}, 32'h0);
      fin;
      chk(n_abort - a, 1);
      chk(n_irq - b, 0);
      rdchk(8'h40, 32'h2000);
      $display("test abort done");
   endtask : t_abort

   task automatic t_dma;
      int b, q, c;
      for (int m = 1; m < 4; m += 2) begin
         bus(1'b1, `ACB_OFS_DMACFG, 32'(m));
         cfg(ON, 32'h5);
         b = n_irq;
         q = n_req;
         c = n_inc;
         go(5'd4, 5'd1, 16'h5000);
         fin;
         chk(n_irq - b, 4);
         chk(n_req - q, 4);
         chk(n_inc - c, (m == 1) ? 2 : 4);
         chk({16'h0, ddata}, 32'h5003);
         rdchk(`ACB_OFS_CTRL1, ON | 32'h1);
      end
      $display("test dma done");
   endtask : t_dma

   task automatic t_pd;
      cfg(ON, 32'h0);
      bus(1'b1, `ACB_OFS_PCFG, 32'h000f);
      pd <= 1'b1;
      wt(6);
      chk({16'h0, din_en}, 32'hffff);
      chk({30'h0, cen, cclk}, 32'h0);
      bus(1'b1, `ACB_OFS_PCFG, 32'h00ff);
      rdchk(`ACB_OFS_PCFG, 32'h0);
      pd <= 1'b0;
      wt(6);
      rdchk(`ACB_OFS_CTRL1, 32'h0);
      rdchk(`ACB_OFS_DMACFG, 32'h0);
      chk({15'h0, din_en, cclk}, 32'h1);
      $display("test power done");
   endtask : t_pd

   initial begin
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      pd = 1'b0;
      start = 1'b0;
      pins = 16'h5a5a;
      cnt = 5'd0;
      gap = 5'd1;
      seed = 16'h0;
      arst_n_i = 1'b0;
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_pins();
      t_count();
      t_split();
      t_abort();
      t_dma();
      t_pd();
      report_and_stop();
   end
endmodule : test_acb_ctrl
`default_nettype wire
